// File: core/debug_rom_oslock_map.vh
// Register selectors, field positions and reset values for the debug register group
`ifndef DEBUG_ROM_OSLOCK_MAP_VH
`define DEBUG_ROM_OSLOCK_MAP_VH

// Coprocessor register selectors (no memory-mapped offset exists)
`define SEL_ROM_TABLE_BASE 3'h0
`define SEL_BKPT_EXT_VALUE0 3'h1
`define SEL_BKPT_EXT_VALUE1 3'h2
`define SEL_OS_LOCK_ACCESS 3'h3
`define SEL_OS_LOCK_STATUS 3'h4

`define ROM_ADDR_HI_MSB 39
`define ROM_ADDR_HI_LSB 32
`define ROM_ADDR_LO_MSB 31
`define ROM_ADDR_LO_LSB 12
`define ROM_VALID_MSB 1
`define ROM_VALID_LSB 0
`define ROM_VALID_SET 2'h3
`define ROM_VALID_CLR 2'h0

`define VIRTUAL_MACHINE_ID_MSB 7
`define VIRTUAL_MACHINE_ID_RESET 8'h00

`define OS_LOCK_KEY 32'hC5ACCE55
`define LOCK_MODEL_VALUE 2'h2
`define LOCK_MODEL_LO_BIT 0
`define LOCK_HELD_BIT 1
`define WIDE_ACCESS_BIT 2
`define LOCK_MODEL_HI_BIT 3
`define LOCK_HELD_RESET 1'h0

`define CONTEXT_CMP_COUNT 4'h2
`define SR_COUNT_RESET 8'h00

`endif

// File: core/debug_rom_oslock_regs.v
// Debug ROM table base, breakpoint extended value and OS lock registers
`timescale 1ns/1ps
`include "debug_rom_oslock_map.vh"

module debug_rom_oslock_regs #(
	parameter [39:12] ROM_TABLE_ADDR = 28'h0000000,
	parameter ROM_TABLE_PRESENT = 1,
	parameter LOCK_MODEL_PRESENT = 1
) (
	input wire clk,
	input wire reset,
	input wire cp_read,
	input wire cp_pair,
	input wire cp_write,
	input wire [2:0] cp_sel,
	input wire [31:0] cp_wdata,
	input wire sr_step,
	output reg [63:0] cp_rdata,
	output reg cp_rvalid,
	output reg [7:0] virtual_machine_id_pair0,
	output reg [7:0] virtual_machine_id_pair1,
	output reg os_locked,
	output reg [7:0] sr_count,
	output reg [3:0] context_cmp_count
);

	reg lock_held_flag_q;
	reg lock_held_flag_d;
	reg [7:0] sr_count_q;
	reg [7:0] sr_count_d;
	reg [63:0] rdata_d;
	reg [63:0] read_data_d;
	reg read_valid_d;
	reg [7:0] virtual_machine_id_pair0_d;
	reg [7:0] virtual_machine_id_pair1_d;
	reg os_locked_d;
	reg [7:0] sr_count_out_d;
	reg [3:0] context_cmp_count_d;
	reg [63:0] rom_table_base_reg;
	reg [31:0] os_lock_status_reg;
	reg [7:0] rom_addr_hi;
	reg [19:0] rom_addr_lo;
	reg [1:0] rom_valid_bits;
	wire [7:0] vmid0_q;
	wire [7:0] vmid1_q;
	wire [1:0] lock_model_field;
	wire key_write;
	wire lock_write;
	wire sel_rom_base;
	wire sel_ext_value0;
	wire sel_ext_value1;
	wire sel_lock_access;
	wire sel_lock_status;
	wire [63:0] rom_pair_view;
	wire [63:0] rom_single_view;
	wire [63:0] ext_value0_view;
	wire [63:0] ext_value1_view;
	wire [63:0] lock_status_view;
	wire [7:0] sr_count_inc;

	// One-hot decode of the selector
	sel_match #(
		.SEL_CODE(`SEL_ROM_TABLE_BASE)
	) sel_match_rom_i (
		.cp_sel(cp_sel),
		.hit(sel_rom_base)
	);

	sel_match #(
		.SEL_CODE(`SEL_BKPT_EXT_VALUE0)
	) sel_match_ext0_i (
		.cp_sel(cp_sel),
		.hit(sel_ext_value0)
	);

	sel_match #(
		.SEL_CODE(`SEL_BKPT_EXT_VALUE1)
	) sel_match_ext1_i (
		.cp_sel(cp_sel),
		.hit(sel_ext_value1)
	);

	sel_match #(
		.SEL_CODE(`SEL_OS_LOCK_ACCESS)
	) sel_match_access_i (
		.cp_sel(cp_sel),
		.hit(sel_lock_access)
	);

	sel_match #(
		.SEL_CODE(`SEL_OS_LOCK_STATUS)
	) sel_match_status_i (
		.cp_sel(cp_sel),
		.hit(sel_lock_status)
	);

	assign lock_write = cp_write & sel_lock_access;
	assign key_write = lock_write & (cp_wdata == `OS_LOCK_KEY);
	assign lock_model_field = LOCK_MODEL_PRESENT ?
		`LOCK_MODEL_VALUE : 2'h0;
	assign sr_count_inc = sr_count_q + 8'h01;

	// Extended value slots, one per context-compare breakpoint pair
	ext_value_slot #(
		.SLOT_SEL(`SEL_BKPT_EXT_VALUE0)
	) ext_value_slot0_i (
		.clk(clk),
		.reset(reset),
		.cp_write(cp_write),
		.cp_sel(cp_sel),
		.cp_wdata(cp_wdata),
		.virtual_machine_id_q(vmid0_q)
	);

	ext_value_slot #(
		.SLOT_SEL(`SEL_BKPT_EXT_VALUE1)
	) ext_value_slot1_i (
		.clk(clk),
		.reset(reset),
		.cp_write(cp_write),
		.cp_sel(cp_sel),
		.cp_wdata(cp_wdata),
		.virtual_machine_id_q(vmid1_q)
	);

	// ROM table fields; an absent table reads all zero with valid clear
	always @* begin
		rom_addr_hi = 8'h00;
		rom_addr_lo = 20'h00000;
		rom_valid_bits = `ROM_VALID_CLR;
		if (ROM_TABLE_PRESENT) begin
			rom_addr_hi = ROM_TABLE_ADDR[39:32];
			rom_addr_lo = ROM_TABLE_ADDR[31:12];
			rom_valid_bits = `ROM_VALID_SET;
		end
	end

	// Static base register view
	always @* begin
		rom_table_base_reg = 64'h0000000000000000;
		rom_table_base_reg[`ROM_ADDR_HI_MSB:`ROM_ADDR_HI_LSB] =
			rom_addr_hi;
		rom_table_base_reg[`ROM_ADDR_LO_MSB:`ROM_ADDR_LO_LSB] =
			rom_addr_lo;
		rom_table_base_reg[`ROM_VALID_MSB:`ROM_VALID_LSB] =
			rom_valid_bits;
	end

	always @* begin
		os_lock_status_reg = 32'h00000000;
		os_lock_status_reg[`LOCK_MODEL_LO_BIT] = lock_model_field[0];
		os_lock_status_reg[`LOCK_MODEL_HI_BIT] = lock_model_field[1];
		os_lock_status_reg[`LOCK_HELD_BIT] = lock_held_flag_q;
		os_lock_status_reg[`WIDE_ACCESS_BIT] = 1'b0;
	end

	// Read views; single reads return the low word only
	assign rom_pair_view = rom_table_base_reg;
	assign rom_single_view =
		{32'h00000000, rom_table_base_reg[31:0]};
	assign ext_value0_view = {56'h00000000000000, vmid0_q};
	assign ext_value1_view = {56'h00000000000000, vmid1_q};
	assign lock_status_view = {32'h00000000, os_lock_status_reg};

	always @* begin
		rdata_d = 64'h0000000000000000;
		case (cp_sel)
			`SEL_ROM_TABLE_BASE: begin
				if (cp_pair) begin
					rdata_d = rom_pair_view;
				end else begin
					rdata_d = rom_single_view;
				end
			end
			`SEL_BKPT_EXT_VALUE0: begin
				rdata_d = ext_value0_view;
			end
			`SEL_BKPT_EXT_VALUE1: begin
				rdata_d = ext_value1_view;
			end
			`SEL_OS_LOCK_STATUS: begin
				rdata_d = lock_status_view;
			end
			default: begin
				rdata_d = 64'h0000000000000000;
			end
		endcase
	end

	// Next value of the lock flag; the last lock access write decides
	always @* begin
		lock_held_flag_d = lock_held_flag_q;
		if (lock_write) begin
			lock_held_flag_d = key_write;
		end
	end

	// A key write wins over a step in the same cycle
	always @* begin
		sr_count_d = sr_count_q;
		if (key_write) begin
			sr_count_d = `SR_COUNT_RESET;
		end else if (sr_step) begin
			sr_count_d = sr_count_inc;
		end
	end

	// Next values of the registered outputs
	always @* begin
		read_data_d = 64'h0000000000000000;
		if (cp_read) begin
			read_data_d = rdata_d;
		end
		read_valid_d = cp_read;
		virtual_machine_id_pair0_d = vmid0_q;
		virtual_machine_id_pair1_d = vmid1_q;
		os_locked_d = lock_held_flag_q;
		sr_count_out_d = sr_count_q;
		context_cmp_count_d = `CONTEXT_CMP_COUNT;
	end

	always @(posedge clk) begin
		if (reset) begin
			lock_held_flag_q <= `LOCK_HELD_RESET;
		end else begin
			lock_held_flag_q <= lock_held_flag_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			sr_count_q <= `SR_COUNT_RESET;
		end else begin
			sr_count_q <= sr_count_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			cp_rdata <= 64'h0000000000000000;
		end else begin
			cp_rdata <= read_data_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			cp_rvalid <= 1'b0;
		end else begin
			cp_rvalid <= read_valid_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			virtual_machine_id_pair0 <= `VIRTUAL_MACHINE_ID_RESET;
		end else begin
			virtual_machine_id_pair0 <= virtual_machine_id_pair0_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			virtual_machine_id_pair1 <= `VIRTUAL_MACHINE_ID_RESET;
		end else begin
			virtual_machine_id_pair1 <= virtual_machine_id_pair1_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			os_locked <= 1'b0;
		end else begin
			os_locked <= os_locked_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			sr_count <= `SR_COUNT_RESET;
		end else begin
			sr_count <= sr_count_out_d;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			context_cmp_count <= 4'h0;
		end else begin
			context_cmp_count <= context_cmp_count_d;
		end
	end

endmodule

// Selector match: high while the selector names one register
module sel_match #(
	parameter [2:0] SEL_CODE = 3'h0
) (
	input wire [2:0] cp_sel,
	output wire hit
);

	assign hit = (cp_sel == SEL_CODE);

endmodule

// Extended value slot: keeps the VM ID byte of one breakpoint pair
module ext_value_slot #(
	parameter [2:0] SLOT_SEL = 3'h0
) (
	input wire clk,
	input wire reset,
	input wire cp_write,
	input wire [2:0] cp_sel,
	input wire [31:0] cp_wdata,
	output reg [7:0] virtual_machine_id_q
);

	wire slot_write;

	assign slot_write = cp_write & (cp_sel == SLOT_SEL);

	// Upper bits of the written word are dropped
	always @(posedge clk) begin
		if (reset) begin
			virtual_machine_id_q <= `VIRTUAL_MACHINE_ID_RESET;
		end else if (slot_write) begin
			virtual_machine_id_q <= cp_wdata[`VIRTUAL_MACHINE_ID_MSB:0];
		end
	end

endmodule

// File: tb/debug_rom_oslock_regs_asserts.sv
// Port checker for the debug ROM base and OS lock registers
`timescale 1ns/1ps
`include "debug_rom_oslock_map.vh"
module debug_rom_oslock_regs_chk (
	input wire clk,
	input wire reset,
	input wire cp_read,
	input wire cp_pair,
	input wire cp_write,
	input wire [2:0] cp_sel,
	input wire [31:0] cp_wdata,
	input wire [63:0] cp_rdata,
	input wire cp_rvalid,
	input wire os_locked,
	input wire [7:0] sr_count,
	input wire [3:0] context_cmp_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire lk_wr = cp_write && cp_sel == 3'h3;
	wire key_wr = lk_wr && cp_wdata == `OS_LOCK_KEY;
	wire rd_st = cp_read && cp_sel == 3'h4;
	chk_read_answer: assert property (cp_read |=> cp_rvalid)
		else $error("read not answered");
	chk_single_hi: assert property
		(cp_read && !cp_pair |=> cp_rdata[63:32] == 32'h0) else $error("hi");
	chk_rom_fields: assert property (cp_read && cp_sel == 3'h0 |=>
		cp_rdata[11:2] == 10'h0 && cp_rdata[1] == cp_rdata[0]) else $error("rom");
	chk_lock_model: assert property
		(rd_st |=> {cp_rdata[3:2], cp_rdata[0]} == 3'h4) else $error("model");
	chk_lock_status: assert property
		(rd_st |=> cp_rdata[1] == os_locked) else $error("status");
	chk_key_locks: assert property
		(key_wr |=> ##1 os_locked) else $error("no lock");
	chk_other_unlocks: assert property
		(lk_wr && !key_wr |=> ##1 !os_locked) else $error("no unlock");
	chk_key_count: assert property
		(key_wr |=> ##1 sr_count == 8'h00) else $error("count");
	chk_ctx_count: assert property
		(!$past(reset) |-> context_cmp_count == 4'h2) else $error("ctx");
	cover property (key_wr);
	cover property (cp_read && cp_pair && cp_sel == 3'h0);
	cover property (lk_wr && !key_wr);
endmodule
bind debug_rom_oslock_regs debug_rom_oslock_regs_chk
	debug_rom_oslock_regs_chk_i (.clk(clk), .reset(reset), .cp_read(cp_read),
	.cp_pair(cp_pair), .cp_write(cp_write), .cp_sel(cp_sel),
	.cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid),
	.os_locked(os_locked), .sr_count(sr_count),
	.context_cmp_count(context_cmp_count));

// File: tb/debug_rom_oslock_regs_tb_top.sv
// Self-checking bench for the debug ROM base and OS lock registers
`timescale 1ns/1ps
`include "debug_rom_oslock_map.vh"
module debug_rom_oslock_regs_tb_top;
	reg clk, reset, cp_read, cp_pair, cp_write, sr_step;
	reg [2:0] cp_sel;
	reg [31:0] cp_wdata;
	wire [63:0] cp_rdata;
	wire cp_rvalid, os_locked;
	wire [7:0] virtual_machine_id_pair0, virtual_machine_id_pair1, sr_count;
	wire [3:0] context_cmp_count;
	integer bad_count, n_compared;
	debug_rom_oslock_regs #(.ROM_TABLE_ADDR(28'hAB12345))
		debug_rom_oslock_regs_i (.clk(clk), .reset(reset), .cp_read(cp_read),
		.cp_pair(cp_pair), .cp_write(cp_write), .cp_sel(cp_sel),
		.cp_wdata(cp_wdata), .sr_step(sr_step), .cp_rdata(cp_rdata),
		.cp_rvalid(cp_rvalid), .virtual_machine_id_pair0(virtual_machine_id_pair0),
		.virtual_machine_id_pair1(virtual_machine_id_pair1), .os_locked(os_locked), .sr_count(sr_count),
		.context_cmp_count(context_cmp_count));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	task check(input ok, input string msg);
		n_compared = n_compared + 1;
		if (!ok) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task rd(input [2:0] s, input p, input [63:0] e);
		@(posedge clk);
		cp_read <= 1'h1;
		cp_sel <= s;
		cp_pair <= p;
		@(posedge clk);
		cp_read <= 1'h0;
		#1 check(cp_rvalid === 1'h1 && cp_rdata === e, "read data");
	endtask
	task wr(input [2:0] s, input [31:0] d);
		@(posedge clk);
		cp_write <= 1'h1;
		cp_sel <= s;
		cp_wdata <= d;
		@(posedge clk);
		cp_write <= 1'h0;
	endtask
	task t_rom;
		rd(3'h0, 1'h0, 64'h12345003);
		rd(3'h0, 1'h1, 64'hAB12345003);
		wr(3'h0, 32'h0);
		rd(3'h0, 1'h1, 64'hAB12345003);
		rd(3'h5, 1'h1, 64'h0);
		$display("rom table test done");
	endtask
	task t_virtual_machine_id;
		wr(3'h1, 32'hFFFFFF5A);
		wr(3'h2, 32'h000000C3);
		rd(3'h1, 1'h0, 64'h5A);
		rd(3'h2, 1'h0, 64'hC3);
		check(virtual_machine_id_pair0 === 8'h5A && virtual_machine_id_pair1 === 8'hC3, "virtual_machine_id");
		$display("extended value test done");
	endtask
	task t_lock;
		wr(3'h3, `OS_LOCK_KEY);
		rd(3'h4, 1'h0, 64'hA);
		check(os_locked === 1'h1, "locked");
		rd(3'h3, 1'h0, 64'h0);
		wr(3'h3, 32'hC5ACCE54);
		rd(3'h4, 1'h0, 64'h8);
		check(os_locked === 1'h0, "unlocked");
		$display("lock test done");
	endtask
	task t_count;
		@(posedge clk);
		sr_step <= 1'h1;
		repeat (3) @(posedge clk);
		sr_step <= 1'h0;
		repeat (2) @(posedge clk);
		#1 check(sr_count === 8'h03, "count up");
		wr(3'h3, `OS_LOCK_KEY);
		repeat (2) @(posedge clk);
		#1 check(sr_count === 8'h00, "count clear");
		check(context_cmp_count === 4'h2, "pairs");
		$display("counter test done");
	endtask
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{reset, cp_read, cp_pair, cp_write, sr_step} = 5'h10;
		cp_sel = 3'h0;
		cp_wdata = 32'h0;
		bad_count = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		t_rom;
		t_virtual_machine_id;
		t_lock;
		t_count;
		stop_test;
	end
endmodule
